// [rtl/dma_pkg.sv]
// constants and types shared by the single dma channel engine
`default_nettype none
package dma_pkg;
    // register offsets (byte addresses on the 8-bit register port)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h04;
    localparam logic [7:0] OFF_IO_ADDR = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_FULL_SRC = 8'h10;
    localparam logic [7:0] OFF_FULL_DST = 8'h14;
    localparam logic [7:0] OFF_FULL_COUNT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;

    // channel_control_reg field positions
    localparam int CTRL_W = 15;
    localparam int CTL_EN = 0;
    localparam int CTL_IRQ_EN = 1;
    localparam int CTL_SIZE = 2;
    localparam int CTL_DEC = 3;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_SRC_LO = 6;
    localparam int CTL_BURST = 9;
    localparam int CTL_SDIR_LO = 10;
    localparam int CTL_DDIR_LO = 12;
    localparam int CTL_EDGE = 14;

    // status field positions
    localparam int STS_BUSY = 0;
    localparam int STS_EXT_PEND = 1;
    localparam int STS_BUS_REQ = 2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [7:0] IO_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // fixed upper bits of the short i/o address
    localparam logic [15:0] IO_UPPER = 16'hffff;
    // address steps for byte and word units
    localparam logic [23:0] STEP_BYTE = 24'h000001;
    localparam logic [23:0] STEP_WORD = 24'h000002;

    typedef enum logic [1:0] {MODE_IDLE, MODE_REPEAT, MODE_NORMAL, MODE_RSVD} mode_t;
    typedef enum logic [2:0] {
        SRC_TMR0, SRC_TMR1, SRC_TMR2, SRC_TMR3, SRC_TX, SRC_RX, SRC_EXT, SRC_AUTO
    } src_t;
    typedef enum logic [1:0] {DIR_FIXED, DIR_INC, DIR_DEC, DIR_RSVD} dir_t;
endpackage : dma_pkg
`default_nettype wire

// [rtl/dma_channel_idle_repeat_normal.sv]
// one dma channel: idle, repeat and normal transfer modes
//
// How it works
// - idle: count down per transfer; at zero clear enable, end, raise interrupt
// - idle: start count of zero gives 65,536 transfers
// - idle/repeat take timer 0-3, serial empty/full and external requests
// - repeat: one unit per request, restore address and count, keep going
// - idle/repeat: serial receive-full moves io to memory; all else memory to io
// - repeat: current count decrements, reloads from unchanged initial count at zero
// - repeat reload subtracts signed initial count times unit size from address
// - repeat runs until enable cleared; setting it again resumes saved state
// - repeat never raises a completion interrupt
// - io address is all-ones upper bits plus 8-bit register, never stepped
// - repeat count is 8-bit, at most 256 transfers
// - normal: both halves form one channel, one unit per request
// - normal: 24-bit source and destination each step or hold independently
// - normal: count down; at zero clear enable; interrupt only if enabled
// - normal: start count of zero gives 65,536 transfers
// - normal: external or auto request; auto runs all transfers unprompted
// - cycle-steal releases the bus after every transfer
// - normal burst with auto or level-held external request keeps the bus to the end unless a higher master asks
// - idle: memory and io addresses stay unchanged
// - on-chip request source is withheld from cpu and its flag cleared
// - edge sensing: one unit per falling edge of the external request
//
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
module dma_channel_idle_repeat_normal (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // activation sources
    input wire logic [3:0] i_timer_req,
    input wire logic i_tx_empty_req,
    input wire logic i_rx_full_req,
    input wire logic i_ext_req_n,
    output logic [5:0] o_req_clear,
    output logic [5:0] o_cpu_withhold,
    // system bus master
    output logic o_bus_req,
    input wire logic i_bus_grant,
    input wire logic i_bus_preempt,
    output logic [23:0] o_bus_addr,
    output logic o_bus_rd,
    output logic o_bus_wr,
    output logic o_bus_word,
    output logic [15:0] o_bus_wdata,
    input wire logic [15:0] i_bus_rdata,
    // completion
    output logic o_done_irq
);
    typedef enum logic [2:0] {S_WAIT, S_GRANT, S_READ, S_DATA, S_WRITE} state_t;

    state_t state;
    logic [dma_pkg::CTRL_W-1:0] channel_control_reg;
    logic [23:0] memory_address_reg;
    logic [7:0] fixed_io_address_reg;
    logic [15:0] transfer_count_reg;
    logic [23:0] full_source_address;
    logic [23:0] full_dest_address;
    logic [15:0] full_transfer_count;
    logic ext_prev;
    logic ext_pend;
    logic rx_dir;

    // address step shared by memory, source and destination pointers
    function automatic logic [23:0] step_addr(input logic [23:0] a, input dma_pkg::dir_t d,
                                              input logic word);
        logic [23:0] inc;
        inc = word ? dma_pkg::STEP_WORD : dma_pkg::STEP_BYTE;
        unique case (d)
            dma_pkg::DIR_INC: step_addr = a + inc;
            dma_pkg::DIR_DEC: step_addr = a - inc;
            default: step_addr = a;
        endcase
    endfunction : step_addr

    // control field decode
    logic transfer_enable_bit;
    logic completion_irq_enable;
    logic unit_size_select;
    logic address_decrement_select;
    logic burst_sel;
    logic edge_sense;
    dma_pkg::mode_t mode;
    dma_pkg::src_t src_sel;
    dma_pkg::dir_t src_dir;
    dma_pkg::dir_t dst_dir;
    assign transfer_enable_bit = channel_control_reg[dma_pkg::CTL_EN];
    assign completion_irq_enable = channel_control_reg[dma_pkg::CTL_IRQ_EN];
    assign unit_size_select = channel_control_reg[dma_pkg::CTL_SIZE];
    assign address_decrement_select = channel_control_reg[dma_pkg::CTL_DEC];
    assign burst_sel = channel_control_reg[dma_pkg::CTL_BURST];
    assign edge_sense = channel_control_reg[dma_pkg::CTL_EDGE];
    assign mode = dma_pkg::mode_t'(channel_control_reg[dma_pkg::CTL_MODE_LO +: 2]);
    assign src_sel = dma_pkg::src_t'(channel_control_reg[dma_pkg::CTL_SRC_LO +: 3]);
    assign src_dir = dma_pkg::dir_t'(channel_control_reg[dma_pkg::CTL_SDIR_LO +: 2]);
    assign dst_dir = dma_pkg::dir_t'(channel_control_reg[dma_pkg::CTL_DDIR_LO +: 2]);

    logic is_idle;
    logic is_repeat;
    logic is_normal;
    assign is_idle = (mode == dma_pkg::MODE_IDLE);
    assign is_repeat = (mode == dma_pkg::MODE_REPEAT);
    assign is_normal = (mode == dma_pkg::MODE_NORMAL);

    // repeat counts live in the two halves of the count register
    logic [7:0] repeat_current_count;
    logic [7:0] repeat_initial_count;
    assign repeat_current_count = transfer_count_reg[15:8];
    assign repeat_initial_count = transfer_count_reg[7:0];

    // register port write hits
    logic wr_ctrl;
    logic wr_mem;
    logic wr_io;
    logic wr_cnt;
    logic wr_src;
    logic wr_dst;
    logic wr_fcnt;
    assign wr_ctrl = i_reg_wr && (i_reg_addr == dma_pkg::OFF_CTRL);
    assign wr_mem = i_reg_wr && (i_reg_addr == dma_pkg::OFF_MEM_ADDR);
    assign wr_io = i_reg_wr && (i_reg_addr == dma_pkg::OFF_IO_ADDR);
    assign wr_cnt = i_reg_wr && (i_reg_addr == dma_pkg::OFF_COUNT);
    assign wr_src = i_reg_wr && (i_reg_addr == dma_pkg::OFF_FULL_SRC);
    assign wr_dst = i_reg_wr && (i_reg_addr == dma_pkg::OFF_FULL_DST);
    assign wr_fcnt = i_reg_wr && (i_reg_addr == dma_pkg::OFF_FULL_COUNT);

    // activation source qualification
    logic [5:0] int_req;
    logic int_src;
    logic ext_fall;
    logic req_hit;
    logic start;
    assign int_req = {i_rx_full_req, i_tx_empty_req, i_timer_req};
    assign int_src = !is_normal && (src_sel != dma_pkg::SRC_EXT) &&
                     (src_sel != dma_pkg::SRC_AUTO);
    assign ext_fall = ext_prev && !i_ext_req_n;

    // short modes take on-chip or external requests
    // normal mode takes only external or auto requests
    always_comb begin
        req_hit = 1'b0;
        unique case (src_sel)
            dma_pkg::SRC_EXT: req_hit = edge_sense ? ext_pend : !i_ext_req_n;
            dma_pkg::SRC_AUTO: req_hit = is_normal;
            default: req_hit = !is_normal && int_req[src_sel];
        endcase
    end

    assign start = (state == S_WAIT) && transfer_enable_bit &&
                   (mode != dma_pkg::MODE_RSVD) && req_hit;

    // address selection and per-transfer arithmetic
    logic [23:0] io_full;
    logic [23:0] rd_addr;
    logic [23:0] wr_addr;
    logic [23:0] next_src;
    logic [23:0] next_dst;
    logic [23:0] mem_step;
    logic [23:0] mem_restore;
    logic [23:0] restore_delta;
    logic xfer;
    logic last_xfer;
    logic keep_bus;

    // io address upper bits forced to ones
    assign io_full = {dma_pkg::IO_UPPER, fixed_io_address_reg};
    assign rd_addr = is_normal ? full_source_address :
                     (rx_dir ? io_full : memory_address_reg);
    assign wr_addr = is_normal ? full_dest_address :
                     (rx_dir ? memory_address_reg : io_full);
    // step size follows the unit size
    assign next_src = step_addr(full_source_address, src_dir, unit_size_select);
    assign next_dst = step_addr(full_dest_address, dst_dir, unit_size_select);
    assign mem_step = step_addr(memory_address_reg,
                                address_decrement_select ? dma_pkg::DIR_DEC : dma_pkg::DIR_INC,
                                unit_size_select);
    // undo a whole table pass, sign following the decrement select
    assign restore_delta = {16'h0000, repeat_initial_count} << unit_size_select;
    assign mem_restore = address_decrement_select ? mem_step + restore_delta
                                                  : mem_step - restore_delta;

    assign xfer = (state == S_WRITE);
    // count of one before the update means this transfer is the last
    assign last_xfer = is_normal ? (full_transfer_count == 16'h0001) :
                       (is_idle && transfer_count_reg == 16'h0001);
    // burst holds the bus while work remains and nobody outranks us
    assign keep_bus = is_normal && burst_sel && !i_bus_preempt && !last_xfer &&
                      transfer_enable_bit &&
                      (src_sel == dma_pkg::SRC_AUTO ||
                       (src_sel == dma_pkg::SRC_EXT && !edge_sense && !i_ext_req_n));

    // transfer sequencer and bus strobes; read data return one cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= S_WAIT;
            o_bus_req <= 1'b0;
            o_bus_rd <= 1'b0;
            o_bus_wr <= 1'b0;
            o_bus_word <= 1'b0;
            o_bus_addr <= dma_pkg::ADDR_RESET;
            o_bus_wdata <= 16'h0000;
            rx_dir <= 1'b0;
        end else begin
            unique case (state)
                S_WAIT: begin
                    if (start) begin
                        o_bus_req <= 1'b1;
                        rx_dir <= !is_normal && (src_sel == dma_pkg::SRC_RX);
                        state <= S_GRANT;
                    end
                end
                S_GRANT: begin
                    if (i_bus_grant) begin
                        o_bus_rd <= 1'b1;
                        o_bus_addr <= rd_addr;
                        o_bus_word <= unit_size_select;
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    o_bus_rd <= 1'b0;
                    state <= S_DATA;
                end
                S_DATA: begin
                    o_bus_wr <= 1'b1;
                    o_bus_addr <= wr_addr;
                    o_bus_wdata <= i_bus_rdata;
                    state <= S_WRITE;
                end
                S_WRITE: begin
                    o_bus_wr <= 1'b0;
                    if (keep_bus) begin
                        o_bus_rd <= 1'b1;
                        o_bus_addr <= next_src;
                        state <= S_READ;
                    end else begin
                        // cycle-steal drops the request after each unit
                        o_bus_req <= 1'b0;
                        state <= S_WAIT;
                    end
                end
            endcase
        end
    end

    // external request edge capture; a new edge wins over the consuming start
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ext_prev <= 1'b1;
            ext_pend <= 1'b0;
        end else begin
            ext_prev <= i_ext_req_n;
            // one pending unit per falling edge, extra edges merge
            if (ext_fall && edge_sense)
                ext_pend <= 1'b1;
            else if (start && src_sel == dma_pkg::SRC_EXT)
                ext_pend <= 1'b0;
        end
    end

    // on-chip request handling
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_req_clear <= 6'h00;
            o_cpu_withhold <= 6'h00;
        end else begin
            // clear the source flag on activation, hide it while enabled
            o_req_clear <= (start && int_src) ? 6'(6'h01 << src_sel) : 6'h00;
            o_cpu_withhold <= (transfer_enable_bit && int_src) ? 6'(6'h01 << src_sel) : 6'h00;
        end
    end

    // control register; software write outranks the end-of-run clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            channel_control_reg <= dma_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            channel_control_reg <= i_reg_wdata[dma_pkg::CTRL_W-1:0];
        end else if (xfer && last_xfer) begin
            // enable drops when the count runs out
            channel_control_reg[dma_pkg::CTL_EN] <= 1'b0;
        end
    end

    // short-address registers; repeat state just holds while disabled so a
    // later enable resumes where it stopped
    // hold across disable
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            memory_address_reg <= dma_pkg::ADDR_RESET;
            fixed_io_address_reg <= dma_pkg::IO_RESET;
            transfer_count_reg <= dma_pkg::COUNT_RESET;
        end else begin
            if (wr_io)
                fixed_io_address_reg <= i_reg_wdata[7:0];
            // idle leaves the memory address alone
            if (wr_mem)
                memory_address_reg <= i_reg_wdata[23:0];
            else if (xfer && is_repeat)
                memory_address_reg <= (repeat_current_count == 8'h01) ? mem_restore : mem_step;
            if (wr_cnt) begin
                transfer_count_reg <= i_reg_wdata[15:0];
            end else if (xfer && is_idle) begin
                // zero wraps to ffff, so 65,536 units run
                transfer_count_reg <= transfer_count_reg - 16'h0001;
            end else if (xfer && is_repeat) begin
                // 8-bit count reloads, initial half untouched
                if (repeat_current_count == 8'h01)
                    transfer_count_reg[15:8] <= repeat_initial_count;
                else
                    transfer_count_reg[15:8] <= repeat_current_count - 8'h01;
            end
        end
    end

    // full-address registers for normal mode
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            full_source_address <= dma_pkg::ADDR_RESET;
            full_dest_address <= dma_pkg::ADDR_RESET;
            full_transfer_count <= dma_pkg::COUNT_RESET;
        end else begin
            // one combined channel, two independent pointers
            if (wr_src)
                full_source_address <= i_reg_wdata[23:0];
            else if (xfer && is_normal)
                full_source_address <= next_src;
            if (wr_dst)
                full_dest_address <= i_reg_wdata[23:0];
            else if (xfer && is_normal)
                full_dest_address <= next_dst;
            // zero start also wraps to 65,536 units
            if (wr_fcnt)
                full_transfer_count <= i_reg_wdata[15:0];
            else if (xfer && is_normal)
                full_transfer_count <= full_transfer_count - 16'h0001;
        end
    end

    // completion pulse
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_done_irq <= 1'b0;
        end else begin
            // repeat never ends, so never interrupts; normal gated
            o_done_irq <= xfer && last_xfer && (is_idle || completion_irq_enable);
        end
    end

    // read data, valid the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                dma_pkg::OFF_CTRL: o_reg_rdata <= {17'h00000, channel_control_reg};
                dma_pkg::OFF_MEM_ADDR: o_reg_rdata <= {8'h00, memory_address_reg};
                dma_pkg::OFF_IO_ADDR: o_reg_rdata <= {24'h000000, fixed_io_address_reg};
                dma_pkg::OFF_COUNT: o_reg_rdata <= {16'h0000, transfer_count_reg};
                dma_pkg::OFF_FULL_SRC: o_reg_rdata <= {8'h00, full_source_address};
                dma_pkg::OFF_FULL_DST: o_reg_rdata <= {8'h00, full_dest_address};
                dma_pkg::OFF_FULL_COUNT: o_reg_rdata <= {16'h0000, full_transfer_count};
                dma_pkg::OFF_STATUS: o_reg_rdata <= {29'h00000000, o_bus_req, ext_pend,
                                                     state != S_WAIT};
                default: o_reg_rdata <= 32'h00000000;
            endcase
        end else begin
            o_reg_rdata <= 32'h00000000;
        end
    end

    // checks on the transfer behaviour
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_idle_count_dec: assert property (
        xfer && is_idle && !i_reg_wr |=> transfer_count_reg == $past(transfer_count_reg) - 16'h0001)
        else $error("idle count did not step down by one");
    a_idle_end_irq: assert property (
        xfer && is_idle && transfer_count_reg == 16'h0001 && !i_reg_wr
        |=> !transfer_enable_bit && o_done_irq ##1 !o_done_irq)
        else $error("idle end did not clear enable and pulse interrupt");
    a_idle_addr_hold: assert property (
        xfer && is_idle && !i_reg_wr |=> $stable(memory_address_reg))
        else $error("idle mode moved the memory address");
    a_repeat_reload: assert property (
        xfer && is_repeat && repeat_current_count == 8'h01 && !i_reg_wr
        |=> repeat_current_count == repeat_initial_count && $stable(repeat_initial_count))
        else $error("repeat count not reloaded from initial count");
    a_repeat_no_irq: assert property (
        xfer && is_repeat |=> !o_done_irq)
        else $error("repeat mode raised a completion interrupt");
    a_io_upper_ones: assert property (
        o_bus_wr && !is_normal && !rx_dir |-> o_bus_addr[23:8] == 16'hffff)
        else $error("io write address upper bits not all ones");
    a_enable_gate: assert property (
        state == S_WAIT && !transfer_enable_bit |=> !o_bus_req)
        else $error("bus requested while channel disabled");
    a_steal_release: assert property (
        xfer && !keep_bus |=> !o_bus_req ##1 (!o_bus_rd && !o_bus_wr))
        else $error("bus not released after a cycle-steal transfer");
    a_normal_irq_gate: assert property (
        xfer && is_normal && full_transfer_count == 16'h0001 && !completion_irq_enable
        && !i_reg_wr |=> !o_done_irq && !transfer_enable_bit)
        else $error("normal end interrupt not gated by enable");
    a_src_word_step: assert property (
        xfer && is_normal && src_dir == dma_pkg::DIR_INC && unit_size_select && !wr_src
        |=> full_source_address == $past(full_source_address) + 24'h000002)
        else $error("word source address did not advance by two");
    a_read_then_write: assert property (
        $rose(o_bus_rd) |=> !o_bus_rd ##1 o_bus_wr ##1 !o_bus_wr)
        else $error("transfer did not pair one read with one write");

    c_repeat_wrap: cover property (xfer && is_repeat && repeat_current_count == 8'h01);
    c_burst_chain: cover property (xfer && keep_bus ##1 o_bus_rd);
    c_idle_done: cover property (xfer && is_idle && last_xfer ##1 o_done_irq);
    c_rx_direction: cover property (o_bus_rd && rx_dir);
endmodule : dma_channel_idle_repeat_normal
`default_nettype wire

// [tb/dma_bus_partner.sv]
// system bus partner: memory with a grant that may lag the request
`default_nettype none
module dma_bus_partner (
    // bus side
    input wire logic i_clk_sys,
    input wire logic i_bus_req,
    input wire logic i_grant_ok,
    input wire logic i_bus_rd,
    input wire logic [23:0] i_bus_addr,
    output logic o_bus_grant,
    output logic [15:0] o_bus_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // grant follows the request, stalled on random cycles
    assign o_bus_grant = i_bus_req & i_grant_ok;
    // data valid only the cycle after the strobe; toggles so stale data never matches
    always_ff @(posedge i_clk_sys) begin
        o_bus_rdata <= i_bus_rd ? (i_bus_addr[15:0] ^ 16'ha5c3) : ~o_bus_rdata;
    end
endmodule : dma_bus_partner
`default_nettype wire

// [tb/dma_channel_idle_repeat_normal_tb_top.sv]
// self-checking bench: register setup, transfers in all three modes
`default_nettype none
module dma_channel_idle_repeat_normal_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ok = 1'b0, grant, breq, brd, bwr, bw, irq;
    logic ext_n = 1'b1, pre = 1'b0;
    logic [7:0] ra = 8'h00, io;
    logic [31:0] rw = 32'h0, rdat;
    logic [5:0] req = 6'h00, set_req = 6'h00, clr, wh;
    logic [23:0] baddr, rd_a, ma, mb;
    logic [15:0] bwd, brdt;
    logic [48:0] e;
    logic [48:0] exq[$];
    int fail_count = 0, checks_done = 0, nwr = 0, nirq = 0, nrel = 0, cyc = 0, rel0 = 0;
    initial forever #5 clk = ~clk;
    dma_channel_idle_repeat_normal dut_u (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(ra),
        .i_reg_wdata(rw), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
        .i_timer_req(req[3:0]), .i_tx_empty_req(req[4]), .i_rx_full_req(req[5]),
        .i_ext_req_n(ext_n), .o_req_clear(clr), .o_cpu_withhold(wh), .o_bus_req(breq),
        .i_bus_grant(grant), .i_bus_preempt(pre), .o_bus_addr(baddr), .o_bus_rd(brd),
        .o_bus_wr(bwr), .o_bus_word(bw), .o_bus_wdata(bwd), .i_bus_rdata(brdt), .o_done_irq(irq));
    dma_bus_partner bus_u (.i_clk_sys(clk), .i_bus_req(breq), .i_grant_ok(ok), .i_bus_rd(brd),
        .i_bus_addr(baddr), .o_bus_grant(grant), .o_bus_rdata(brdt));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); ra <= a; rw <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] x, input string n);
        @(posedge clk); ra <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 check(n, rdat, x);
    endtask : rreg
    // wait for n writes in all, bounded, then let a completion pulse land
    task automatic wait_wr(input int n);
        for (int i = 0; i < 300 && nwr < n; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        check("writes", 32'(nwr), 32'(n));
    endtask : wait_wr
    // request flags are levels, dropped only when the channel clears them
    task automatic fire(input int k, input int n);
        @(posedge clk); set_req <= 6'(1 << k);
        @(posedge clk); set_req <= 6'h00;
        wait_wr(n);
    endtask : fire
    // source flags, random grant stall, bus monitor and model compare
    always @(posedge clk) begin
        req <= (req | set_req) & ~clr;
        ok <= ($urandom % 4) != 0;
        cyc <= cyc + 1;
        if (brd) rd_a <= baddr;
        if (irq) nirq <= nirq + 1;
        if ($fell(breq)) nrel <= nrel + 1;
        if (bwr) begin
            e = exq.pop_front();
            nwr <= nwr + 1;
            check("src_addr", rd_a, e[47:24]);
            check("dst_addr", baddr, e[23:0]);
            check("unit", bw, e[48]);
            check("data", e[48] ? bwd : bwd[7:0],
                  e[48] ? e[39:24] ^ 16'ha5c3 : e[31:24] ^ 8'hc3);
        end
        if (cyc > 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(91));
        ma = 24'h001000 + 24'($urandom % 4096);
        mb = ma + 24'h100000;
        io = 8'($urandom);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rreg(dma_pkg::OFF_CTRL, 32'h0, "ctrl_reset");
        rreg(8'h20, 32'h0, "unmapped");
        wreg(dma_pkg::OFF_MEM_ADDR, 32'(ma));
        wreg(dma_pkg::OFF_IO_ADDR, 32'(io));
        wreg(dma_pkg::OFF_COUNT, 32'h4);
        // idle: one transfer per timer source, addresses held
        for (int k = 0; k < 4; k++) begin
            exq.push_back({1'b0, ma, 16'hffff, io});
            wreg(dma_pkg::OFF_CTRL, 32'((k << 6) | 1));
            fire(k, k + 1);
        end
        check("idle_irq", 32'(nirq), 32'h1);
        check("idle_release", 32'(nrel), 32'h4);
        rreg(dma_pkg::OFF_CTRL, 32'h00c0, "idle_ctrl");
        rreg(dma_pkg::OFF_MEM_ADDR, 32'(ma), "idle_mem");
        fire(3, 4);
        // receive-full moves io to memory
        exq.push_back({1'b0, 16'hffff, io, ma});
        wreg(dma_pkg::OFF_COUNT, 32'h1);
        wreg(dma_pkg::OFF_CTRL, 32'h0141);
        @(posedge clk) #1 check("withhold", 32'(wh), 32'h20);
        fire(5, 5);
        // repeat: two-unit table, reload on second transfer, no interrupt
        exq.push_back({1'b0, ma, 16'hffff, io});
        exq.push_back({1'b0, ma + 24'h1, 16'hffff, io});
        exq.push_back({1'b0, ma, 16'hffff, io});
        wreg(dma_pkg::OFF_COUNT, 32'h0202);
        wreg(dma_pkg::OFF_CTRL, 32'h0111);
        for (int n = 6; n < 9; n++) fire(4, n);
        rreg(dma_pkg::OFF_COUNT, 32'h0102, "rep_count");
        check("rep_irq", 32'(nirq), 32'h2);
        wreg(dma_pkg::OFF_CTRL, 32'h0110);
        fire(4, 8);
        exq.push_back({1'b0, ma + 24'h1, 16'hffff, io});
        wreg(dma_pkg::OFF_CTRL, 32'h0111);
        wait_wr(9);
        // normal auto burst: word units, source up, destination down
        for (int i = 0; i < 3; i++) exq.push_back({1'b1, ma + 24'(2 * i), mb - 24'(2 * i)});
        wreg(dma_pkg::OFF_FULL_SRC, 32'(ma));
        wreg(dma_pkg::OFF_FULL_DST, 32'(mb));
        wreg(dma_pkg::OFF_FULL_COUNT, 32'h3);
        rel0 = nrel;
        wreg(dma_pkg::OFF_CTRL, 32'h27e7);
        wait_wr(12);
        check("burst_release", 32'(nrel - rel0), 32'h1);
        check("norm_irq", 32'(nirq), 32'h3);
        rreg(dma_pkg::OFF_CTRL, 32'h27e6, "norm_ctrl");
        // preempted burst: two units, bus let go after each
        for (int i = 3; i < 5; i++) exq.push_back({1'b1, ma + 24'(2 * i), mb - 24'(2 * i)});
        wreg(dma_pkg::OFF_FULL_COUNT, 32'h2);
        pre <= 1'b1;
        wreg(dma_pkg::OFF_CTRL, 32'h27e7);
        wait_wr(14);
        check("preempt_release", 32'(nrel - rel0), 32'h3);
        check("pre_irq", 32'(nirq), 32'h4);
        // idle, edge-sensed external request: one unit per falling edge
        exq.push_back({1'b0, ma, 16'hffff, io});
        wreg(dma_pkg::OFF_COUNT, 32'h1);
        wreg(dma_pkg::OFF_CTRL, 32'h4181);
        @(posedge clk) ext_n <= 1'b0;
        @(posedge clk) ext_n <= 1'b1;
        wait_wr(15);
        check("ext_irq", 32'(nirq), 32'h5);
        stop_test();
    end
endmodule : dma_channel_idle_repeat_normal_tb_top
`default_nettype wire
